/* hdl/rtcc_regs.vh */
// register indices, field positions, reset values and sync counts of the real-time counter
`ifndef RTCC_REGS_VH
`define RTCC_REGS_VH
`define RTCC_IDX_CTRL 6'h00
`define RTCC_IDX_STATUS 6'h01
`define RTCC_IDX_IRQ_EN 6'h02
`define RTCC_IDX_IRQ_FLAG 6'h03
`define RTCC_IDX_TEMP 6'h04
`define RTCC_IDX_HALT 6'h05
`define RTCC_IDX_SRC 6'h07
`define RTCC_IDX_CNT 6'h08
`define RTCC_IDX_PER 6'h0a
`define RTCC_IDX_CMP 6'h0c
`define RTCC_IDX_PIT_CTRL 6'h10
`define RTCC_IDX_PIT_STAT 6'h11
`define RTCC_IDX_PIT_EN 6'h12
`define RTCC_IDX_PIT_FLAG 6'h13
`define RTCC_IDX_PIT_HALT 6'h15
`define RTCC_CTRL_EN 0
`define RTCC_CTRL_PRESC_LSB 3
`define RTCC_CTRL_PRESC_MSB 6
`define RTCC_CTRL_STDBY 7
`define RTCC_CTRL_MASK 8'hf9
`define RTCC_STAT_CTRL 0
`define RTCC_STAT_CNT 1
`define RTCC_STAT_PER 2
`define RTCC_STAT_CMP 3
`define RTCC_IRQ_WRAP 0
`define RTCC_IRQ_MATCH 1
`define RTCC_HALT_RUN 0
`define RTCC_RST_CTRL 8'h00
`define RTCC_RST_CNT 16'h0000
`define RTCC_RST_PER 16'hffff
`define RTCC_RST_CMP 16'h0000
`define RTCC_RST_SRC 2'h0
`define RTCC_SRC_FAST 2'h0
`define RTCC_SRC_SLOW 2'h1
`define RTCC_SRC_EXT 2'h3
`define RTCC_SYNC_TICKS 2'h2
`define RTCC_RESP_OKAY 2'h0
`define RTCC_RESP_SLVERR 2'h2
`endif

/* hdl/rtcc_src_tick.v */
// counter clock source synchroniser, selector and tick generator
`timescale 1ns/100ps
`default_nettype none
`include "rtcc_regs.vh"
module rtcc_src_tick (
	input wire core_clk,
	input wire rstn,
	input wire internal_fast_source,
	input wire internal_slow_source,
	input wire external_source,
	input wire [1:0] source_choice,
	output reg src_tick_r
);
	reg [2:0] meta_r;
	reg [2:0] sync_r;
	reg [2:0] last_r;
	wire [2:0] rise;
	reg sel_rise;

	assign rise = sync_r & ~last_r;

	always @* begin
		case (source_choice)
			`RTCC_SRC_FAST: sel_rise = rise[0];
			`RTCC_SRC_SLOW: sel_rise = rise[1];
			`RTCC_SRC_EXT: sel_rise = rise[2];
			// reserved code: counter clock stands still
			default: sel_rise = 1'b0;
		endcase
	end

	always @(posedge core_clk) begin
		if (!rstn) begin
			meta_r <= 3'h0;
			sync_r <= 3'h0;
			last_r <= 3'h0;
			src_tick_r <= 1'b0;
		end else begin
			meta_r <= {external_source, internal_slow_source, internal_fast_source};
			sync_r <= meta_r;
			last_r <= sync_r;
			src_tick_r <= sel_rise;
		end
	end
endmodule
`default_nettype wire

/* hdl/rtcc_sync_stage.v */
// holds a software write until two counter clock ticks have passed, then applies it
`timescale 1ns/100ps
`default_nettype none
`include "rtcc_regs.vh"
module rtcc_sync_stage #(
	parameter W = 8,
	parameter [W-1:0] RST = {W{1'b0}}
) (
	input wire core_clk,
	input wire rstn,
	input wire wr_stb,
	input wire [W-1:0] wr_val,
	input wire src_tick,
	output reg busy_r,
	output reg load_r,
	output reg [W-1:0] val_r
);
	reg [W-1:0] hold_r;
	reg [1:0] ticks_r;

	always @(posedge core_clk) begin
		if (!rstn) begin
			hold_r <= RST;
			val_r <= RST;
			ticks_r <= 2'h0;
			busy_r <= 1'b0;
			load_r <= 1'b0;
		end else begin
			load_r <= 1'b0;
			// a new write restarts the crossing, so it is never lost
			if (wr_stb) begin
				hold_r <= wr_val;
				busy_r <= 1'b1;
				ticks_r <= 2'h0;
			end else if (busy_r && src_tick) begin
				if (ticks_r == `RTCC_SYNC_TICKS - 2'h1) begin
					busy_r <= 1'b0;
					load_r <= 1'b1;
					val_r <= hold_r;
				end else begin
					ticks_r <= ticks_r + 2'h1;
				end
			end
		end
	end
endmodule
`default_nettype wire

/* hdl/rtcc_top.v */
// real-time counter: axi4-lite registers, prescaler, 16-bit counter, flags and requests
`timescale 1ns/100ps
`default_nettype none
`include "rtcc_regs.vh"
// Functional notes
// RQ1: counter runs only while counter_on is 1.
// RQ2: in standby the counter runs only when standby_keep_running is 1.
// RQ3: counter clock divided by two to the power of the 4-bit divider field.
// RQ4: control write acts two counter clock ticks after the register update.
// RQ5: software waits for control_sync_pending clear before rewriting control.
// RQ6: status bit 3 high while the match value crosses.
// RQ7: status bit 2 high while the wrap limit crosses.
// RQ8: status bit 1 high while the count value crosses.
// RQ9: status bit 0 high while the control value crosses.
// RQ10: enable bit 1 gates the match request.
// RQ11: enable bit 0 gates the wrap request.
// RQ12: wrap when count reaches the limit; next tick restarts from zero.
// RQ13: hardware sets flags; writing 1 clears, writing 0 keeps.
// RQ14: count and limit writes act two counter ticks later.
// RQ15: source choice 0 fast, 1 slow, 3 external, 2 reserved.
// RQ16: request high while a flag and its enable are both set.
// RQ17: pending flags set on write, clear once the value has crossed.
module rtcc_top (
	input wire core_clk,
	input wire rstn,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire internal_fast_source,
	input wire internal_slow_source,
	input wire external_source,
	input wire standby_sleep,
	input wire cpu_halted,
	output wire irq_req,
	output reg wrap_event_r,
	output reg match_event_r
);
	// write channel holding registers
	reg aw_held_r;
	reg [7:0] aw_addr_r;
	reg w_held_r;
	reg [31:0] w_data_r;
	reg [3:0] w_strb_r;
	// software-side registers
	reg [7:0] ctrl_sw_r;
	reg [1:0] irq_en_r;
	reg [1:0] flag_r;
	reg [7:0] temp_r;
	reg halt_run_r;
	reg [1:0] src_r;
	reg [7:0] pit_ctrl_r;
	reg pit_en_r;
	reg pit_halt_r;
	// counter domain state
	reg [14:0] presc_r;
	reg [15:0] cnt_r;
	reg [15:0] cnt_nxt;
	reg [1:0] flag_set;
	reg [31:0] rd_nxt;

	wire do_wr;
	wire [5:0] wr_idx;
	wire [5:0] rd_idx;
	wire lane0;
	wire lane1;
	wire wr_ctrl;
	wire wr_cnt;
	wire wr_per;
	wire wr_cmp;
	wire [1:0] flag_clr;
	wire src_tick;
	wire [7:0] ctrl_act;
	wire [15:0] cnt_val;
	wire [15:0] per_act;
	wire [15:0] cmp_act;
	wire cnt_load;
	wire ctrl_busy;
	wire cnt_busy;
	wire per_busy;
	wire cmp_busy;
	wire run;
	wire count_tick;
	wire [7:0] status;

	// mapped indices answer okay, holes and out-of-range indices answer slverr
	function mapped;
		input [5:0] idx;
		begin
			case (idx)
				`RTCC_IDX_CTRL, `RTCC_IDX_STATUS, `RTCC_IDX_IRQ_EN, `RTCC_IDX_IRQ_FLAG,
				`RTCC_IDX_TEMP, `RTCC_IDX_HALT, `RTCC_IDX_SRC, `RTCC_IDX_CNT,
				`RTCC_IDX_PER, `RTCC_IDX_CMP, `RTCC_IDX_PIT_CTRL, `RTCC_IDX_PIT_STAT,
				`RTCC_IDX_PIT_EN, `RTCC_IDX_PIT_FLAG, `RTCC_IDX_PIT_HALT: mapped = 1'b1;
				default: mapped = 1'b0;
			endcase
		end
	endfunction

	// byte-lane merge for the 16-bit registers
	function [15:0] merge16;
		input [15:0] old;
		input [15:0] nw;
		input [1:0] strb;
		begin
			merge16 = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
		end
	endfunction

	// low p bits set: prescaler wraps every 2**p source ticks
	function [14:0] presc_mask;
		input [3:0] p;
		begin
			presc_mask = 15'h7fff >> (4'hf - p);
			if (p == 4'h0)
				presc_mask = 15'h0000;
		end
	endfunction

	// ---- axi4-lite write path ----
	assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
	assign s_axi_wready = !w_held_r && !s_axi_bvalid;
	assign do_wr = aw_held_r && w_held_r && !s_axi_bvalid;
	assign wr_idx = aw_addr_r[7:2];
	assign lane0 = w_strb_r[0];
	assign lane1 = w_strb_r[1];
	assign wr_ctrl = do_wr && lane0 && (wr_idx == `RTCC_IDX_CTRL);
	assign wr_cnt = do_wr && (lane0 || lane1) && (wr_idx == `RTCC_IDX_CNT);
	assign wr_per = do_wr && (lane0 || lane1) && (wr_idx == `RTCC_IDX_PER);
	assign wr_cmp = do_wr && (lane0 || lane1) && (wr_idx == `RTCC_IDX_CMP);
	// RQ13: write one to clear
	assign flag_clr = (do_wr && lane0 && wr_idx == `RTCC_IDX_IRQ_FLAG) ? w_data_r[1:0] : 2'h0;

	always @(posedge core_clk) begin
		if (!rstn) begin
			aw_held_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_held_r <= 1'b0;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RTCC_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			if (do_wr) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= mapped(wr_idx) ? `RTCC_RESP_OKAY : `RTCC_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always @(posedge core_clk) begin
		if (!rstn) begin
			ctrl_sw_r <= `RTCC_RST_CTRL;
			irq_en_r <= 2'h0;
			temp_r <= 8'h00;
			halt_run_r <= 1'b0;
			src_r <= `RTCC_RST_SRC;
			pit_ctrl_r <= 8'h00;
			pit_en_r <= 1'b0;
			pit_halt_r <= 1'b0;
		end else if (do_wr && lane0) begin
			case (wr_idx)
				`RTCC_IDX_CTRL: ctrl_sw_r <= w_data_r[7:0] & `RTCC_CTRL_MASK;
				`RTCC_IDX_IRQ_EN: irq_en_r <= w_data_r[1:0];
				`RTCC_IDX_TEMP: temp_r <= w_data_r[7:0];
				`RTCC_IDX_HALT: halt_run_r <= w_data_r[`RTCC_HALT_RUN];
				`RTCC_IDX_SRC: src_r <= w_data_r[1:0];
				`RTCC_IDX_PIT_CTRL: pit_ctrl_r <= w_data_r[7:0] & 8'h79;
				`RTCC_IDX_PIT_EN: pit_en_r <= w_data_r[0];
				`RTCC_IDX_PIT_HALT: pit_halt_r <= w_data_r[0];
				default: temp_r <= temp_r;
			endcase
		end
	end

	// ---- counter clock tick and crossings ----
	// RQ15: source select
	rtcc_src_tick u_src (
		.core_clk(core_clk),
		.rstn(rstn),
		.internal_fast_source(internal_fast_source),
		.internal_slow_source(internal_slow_source),
		.external_source(external_source),
		.source_choice(src_r),
		.src_tick_r(src_tick)
	);

	// RQ4: control crosses over two ticks
	rtcc_sync_stage #(.W(8), .RST(`RTCC_RST_CTRL)) u_ctrl_sync (
		.core_clk(core_clk),
		.rstn(rstn),
		.wr_stb(wr_ctrl),
		.wr_val(w_data_r[7:0] & `RTCC_CTRL_MASK),
		.src_tick(src_tick),
		.busy_r(ctrl_busy),
		.load_r(),
		.val_r(ctrl_act)
	);

	// RQ14: count crosses over two ticks
	rtcc_sync_stage #(.W(16), .RST(`RTCC_RST_CNT)) u_cnt_sync (
		.core_clk(core_clk),
		.rstn(rstn),
		.wr_stb(wr_cnt),
		.wr_val(merge16(cnt_r, w_data_r[15:0], w_strb_r[1:0])),
		.src_tick(src_tick),
		.busy_r(cnt_busy),
		.load_r(cnt_load),
		.val_r(cnt_val)
	);

	// RQ14: limit crosses over two ticks
	rtcc_sync_stage #(.W(16), .RST(`RTCC_RST_PER)) u_per_sync (
		.core_clk(core_clk),
		.rstn(rstn),
		.wr_stb(wr_per),
		.wr_val(merge16(per_act, w_data_r[15:0], w_strb_r[1:0])),
		.src_tick(src_tick),
		.busy_r(per_busy),
		.load_r(),
		.val_r(per_act)
	);

	rtcc_sync_stage #(.W(16), .RST(`RTCC_RST_CMP)) u_cmp_sync (
		.core_clk(core_clk),
		.rstn(rstn),
		.wr_stb(wr_cmp),
		.wr_val(merge16(cmp_act, w_data_r[15:0], w_strb_r[1:0])),
		.src_tick(src_tick),
		.busy_r(cmp_busy),
		.load_r(),
		.val_r(cmp_act)
	);

	// ---- prescaler and counter ----
	// RQ1: enable gate
	// RQ2: standby gate
	assign run = ctrl_act[`RTCC_CTRL_EN] && (!standby_sleep || ctrl_act[`RTCC_CTRL_STDBY])
		&& (halt_run_r || !cpu_halted);
	// RQ3: power-of-two divide
	assign count_tick = run && src_tick
		&& ((presc_r & presc_mask(ctrl_act[`RTCC_CTRL_PRESC_MSB:`RTCC_CTRL_PRESC_LSB]))
		== presc_mask(ctrl_act[`RTCC_CTRL_PRESC_MSB:`RTCC_CTRL_PRESC_LSB]));

	always @* begin
		flag_set = 2'h0;
		cnt_nxt = cnt_r + 16'h0001;
		// RQ12: wrap at the limit
		if (cnt_r == per_act) begin
			cnt_nxt = 16'h0000;
			flag_set[`RTCC_IRQ_WRAP] = count_tick;
		end
		if (count_tick && cnt_nxt == cmp_act)
			flag_set[`RTCC_IRQ_MATCH] = 1'b1;
	end

	always @(posedge core_clk) begin
		if (!rstn) begin
			presc_r <= 15'h0000;
			cnt_r <= `RTCC_RST_CNT;
			flag_r <= 2'h0;
			wrap_event_r <= 1'b0;
			match_event_r <= 1'b0;
		end else begin
			// prescaler is held off with the counter so a restart begins a full period
			if (!run)
				presc_r <= 15'h0000;
			else if (src_tick)
				presc_r <= presc_r + 15'h0001;
			if (cnt_load)
				cnt_r <= cnt_val;
			else if (count_tick)
				cnt_r <= cnt_nxt;
			// RQ13: set beats clear
			flag_r <= (flag_r & ~flag_clr) | flag_set;
			wrap_event_r <= flag_set[`RTCC_IRQ_WRAP];
			match_event_r <= flag_set[`RTCC_IRQ_MATCH];
		end
	end

	// RQ10: match enable
	// RQ11: wrap enable
	// RQ16: level request
	assign irq_req = |(flag_r & irq_en_r);

	// RQ17: pending flags
	// RQ6: match pending
	// RQ7: limit pending
	// RQ8: count pending
	// RQ9: control pending
	assign status = {4'h0, cmp_busy, per_busy, cnt_busy, ctrl_busy};

	// ---- axi4-lite read path ----
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_idx = s_axi_araddr[7:2];

	always @* begin
		rd_nxt = 32'h0000_0000;
		case (rd_idx)
			`RTCC_IDX_CTRL: rd_nxt[7:0] = ctrl_sw_r;
			`RTCC_IDX_STATUS: rd_nxt[7:0] = status;
			`RTCC_IDX_IRQ_EN: rd_nxt[1:0] = irq_en_r;
			`RTCC_IDX_IRQ_FLAG: rd_nxt[1:0] = flag_r;
			`RTCC_IDX_TEMP: rd_nxt[7:0] = temp_r;
			`RTCC_IDX_HALT: rd_nxt[0] = halt_run_r;
			`RTCC_IDX_SRC: rd_nxt[1:0] = src_r;
			`RTCC_IDX_CNT: rd_nxt[15:0] = cnt_r;
			`RTCC_IDX_PER: rd_nxt[15:0] = per_act;
			`RTCC_IDX_CMP: rd_nxt[15:0] = cmp_act;
			`RTCC_IDX_PIT_CTRL: rd_nxt[7:0] = pit_ctrl_r;
			`RTCC_IDX_PIT_EN: rd_nxt[0] = pit_en_r;
			`RTCC_IDX_PIT_HALT: rd_nxt[0] = pit_halt_r;
			default: rd_nxt = 32'h0000_0000;
		endcase
	end

	always @(posedge core_clk) begin
		if (!rstn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `RTCC_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_nxt;
			s_axi_rresp <= mapped(rd_idx) ? `RTCC_RESP_OKAY : `RTCC_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* verification/rtcc_chk.sv */
// port-level assertions for the real-time counter
`timescale 1ns/100ps
`default_nettype none
module rtcc_chk (
	input wire core_clk,
	input wire rstn,
	input wire s_axi_awready,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire irq_req,
	input wire wrap_event_r,
	input wire match_event_r
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);
	a_ready_reset: assert property ($rose(rstn) |-> s_axi_awready && s_axi_wready && s_axi_arready
		&& !s_axi_bvalid && !s_axi_rvalid && !irq_req) else $error("bad state after reset");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken during data");
	a_r_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_wrap_pulse: assert property (wrap_event_r |=> !wrap_event_r) else $error("wrap pulse too long");
	a_match_pulse: assert property (match_event_r |=> !match_event_r) else $error("match pulse too long");
endmodule
`default_nettype wire

/* verification/rtcc_top_test.sv */
// self-checking bench of the real-time counter
`timescale 1ns/100ps
`default_nettype none
`include "rtcc_regs.vh"
module rtcc_top_test;
	reg core_clk = 0, rstn = 0, internal_fast_source = 0, internal_slow_source = 0, external_source = 0;
	reg standby_sleep = 0, cpu_halted = 0, ok = 0;
	reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	reg [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, sc = 0;
	reg [31:0] s_axi_wdata = 0, d = 0, e = 0;
	reg [3:0] s_axi_wstrb = 4'hf;
	reg [1:0] rs = 0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_req, wrap_event_r, match_event_r;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	integer mismatches = 0, checks_done = 0, n;
	rtcc_top u_rtcc_top (.core_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.internal_fast_source, .internal_slow_source, .external_source, .standby_sleep, .cpu_halted,
		.irq_req, .wrap_event_r, .match_event_r);
	initial begin
		forever #10 core_clk = ~core_clk;
	end
	// source clocks of different rates so a wrong selection shows
	always @(posedge core_clk) begin
		sc <= sc + 8'h01;
		internal_fast_source <= sc[2];
		internal_slow_source <= sc[5];
		external_source <= sc[3];
	end
	task chk(input string nm, input [31:0] s, input [31:0] x);
		begin
			checks_done = checks_done + 1;
			if (s !== x) begin
				mismatches = mismatches + 1;
				$display("mismatch %0s expected %h seen %h", nm, x, s);
			end
		end
	endtask
	task wr(input [5:0] i, input [31:0] v);
		begin
			@(posedge core_clk);
			s_axi_awaddr <= {i, 2'h0};
			s_axi_wdata <= v;
			s_axi_awvalid <= 1;
			s_axi_wvalid <= 1;
			s_axi_bready <= 1;
			ok = 0;
			// no latency is assumed here: only the watchdog ends a wait for the answer
			while (!ok) begin
				@(posedge core_clk);
				if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
				if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
				if (s_axi_bvalid) begin
					s_axi_bready <= 0;
					rs = s_axi_bresp;
					ok = 1;
				end
			end
		end
	endtask
	task rc(input string nm, input [5:0] i, input [31:0] x);
		begin
			@(posedge core_clk);
			s_axi_araddr <= {i, 2'h0};
			s_axi_arvalid <= 1;
			s_axi_rready <= 1;
			ok = 0;
			while (!ok) begin
				@(posedge core_clk);
				if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
				if (s_axi_rvalid) begin
					s_axi_rready <= 0;
					d = s_axi_rdata;
					rs = s_axi_rresp;
					ok = 1;
				end
			end
			if (nm != "") chk(nm, d, x);
		end
	endtask
	// software waits for every pending bit to clear before the next write
	task idle;
		integer k;
		begin
			d = 1;
			for (k = 0; k < 60 && d !== 0; k = k + 1) rc("", `RTCC_IDX_STATUS, 0);
			chk("busy_clear", d, 0);
		end
	endtask
	// a frozen counter reads the same value across a gap
	task frz(input r);
		begin
			rc("", `RTCC_IDX_CNT, 0);
			e = d;
			repeat (200) @(posedge core_clk);
			rc("", `RTCC_IDX_CNT, 0);
			chk("moving", d !== e, r);
		end
	endtask
	task t_reset;
		begin
			rc("ctrl", `RTCC_IDX_CTRL, 0);
			rc("status", `RTCC_IDX_STATUS, 0);
			rc("irq_en", `RTCC_IDX_IRQ_EN, 0);
			rc("flags", `RTCC_IDX_IRQ_FLAG, 0);
			rc("cnt", `RTCC_IDX_CNT, 0);
			rc("per", `RTCC_IDX_PER, 32'hffff);
			rc("cmp", `RTCC_IDX_CMP, 0);
			rc("unmapped", 6'h09, 0);
			chk("rresp", rs, `RTCC_RESP_SLVERR);
			wr(6'h06, 1);
			chk("bresp", rs, `RTCC_RESP_SLVERR);
		end
	endtask
	task t_sync;
		begin
			wr(`RTCC_IDX_CNT, 5);
			rc("cnt_busy", `RTCC_IDX_STATUS, 2);
			idle;
			rc("cnt", `RTCC_IDX_CNT, 5);
			wr(`RTCC_IDX_PER, 3);
			rc("per_busy", `RTCC_IDX_STATUS, 4);
			idle;
			rc("per", `RTCC_IDX_PER, 3);
			wr(`RTCC_IDX_CMP, 2);
			rc("cmp_busy", `RTCC_IDX_STATUS, 8);
			idle;
			wr(`RTCC_IDX_CNT, 0);
			idle;
		end
	endtask
	task t_flags;
		begin
			wr(`RTCC_IDX_IRQ_EN, 3);
			wr(`RTCC_IDX_CTRL, 1);
			rc("ctrl_busy", `RTCC_IDX_STATUS, 1);
			for (n = 0; n < 600 && match_event_r !== 1'b1; n = n + 1) @(posedge core_clk);
			chk("match", match_event_r, 1);
			chk("no_early_wrap", wrap_event_r, 0);
			for (n = 0; n < 600 && wrap_event_r !== 1'b1; n = n + 1) @(posedge core_clk);
			chk("wrap", wrap_event_r, 1);
			@(posedge core_clk);
			chk("irq", irq_req, 1);
			wr(`RTCC_IDX_CTRL, 0);
			idle;
			rc("flags", `RTCC_IDX_IRQ_FLAG, 3);
			frz(0);
			wr(`RTCC_IDX_IRQ_EN, 0);
			chk("irq", irq_req, 0);
			wr(`RTCC_IDX_IRQ_EN, 2);
			chk("irq", irq_req, 1);
			wr(`RTCC_IDX_IRQ_FLAG, 2);
			chk("irq", irq_req, 0);
			wr(`RTCC_IDX_IRQ_EN, 1);
			chk("irq", irq_req, 1);
			wr(`RTCC_IDX_IRQ_FLAG, 0);
			rc("flags", `RTCC_IDX_IRQ_FLAG, 1);
			wr(`RTCC_IDX_IRQ_FLAG, 1);
			rc("flags", `RTCC_IDX_IRQ_FLAG, 0);
		end
	endtask
	task t_mode;
		begin
			wr(`RTCC_IDX_PER, 32'hffff);
			wr(`RTCC_IDX_CTRL, 32'h79);
			idle;
			frz(0);
			wr(`RTCC_IDX_CTRL, 32'h09);
			idle;
			frz(1);
			standby_sleep <= 1;
			wr(`RTCC_IDX_CTRL, 1);
			idle;
			frz(0);
			wr(`RTCC_IDX_CTRL, 32'h81);
			idle;
			frz(1);
			standby_sleep <= 0;
			wr(`RTCC_IDX_SRC, 2);
			frz(0);
			wr(`RTCC_IDX_SRC, 1);
			frz(1);
			wr(`RTCC_IDX_SRC, 3);
			frz(1);
			// a halted cpu freezes the counter unless the debug run bit is set
			cpu_halted <= 1;
			frz(0);
			wr(`RTCC_IDX_HALT, 1);
			frz(1);
			cpu_halted <= 0;
		end
	endtask
	task give_verdict;
		begin
			$display("checks %0d mismatches %0d", checks_done, mismatches);
			if (mismatches == 0 && checks_done > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask
	initial begin
		repeat (8) @(posedge core_clk);
		rstn <= 1;
		t_reset;
		$display("test reset done");
		t_sync;
		$display("test sync done");
		t_flags;
		$display("test flags done");
		t_mode;
		$display("test mode done");
		give_verdict;
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		mismatches = mismatches + 1;
		give_verdict;
	end
endmodule
bind rtcc_top rtcc_chk u_rtcc_chk (.core_clk, .rstn, .s_axi_awready, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
	.s_axi_rready, .irq_req, .wrap_event_r, .match_event_r);
`default_nettype wire
